// [dbl_bank_legality.sv]
// Per-bank command state tracking and illegal-command flagging
// Function
// - Chip select high decodes as unselected
// - Autoclose burst runs on; others illegal
// - Closing bank idles after close time
// - Opening bank activates after open time
// - Write recovery returns active; store restarts
// - Recovery with autoclose then closes bank
// - Refresh idles after cycle time, all quiet
// - Mode load idles after load time
// - Other banks may take bank commands
// - Close targets bank or all banks
`timescale 1ns/10ps
`default_nettype none
`include "dbl_consts.svh"
module dbl_bank_legality #(
   parameter int BANKS = 8,
   parameter int BA_W = 3,
   parameter int ADDR_W = 14
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic chip_sel_n,
   input wire logic row_strobe_n,
   input wire logic column_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [BA_W-1:0] bank_addr,
   input wire logic [ADDR_W-1:0] addr,
   output logic illegal_cmd,
   output dbl_pkg::dbl_cmd_t last_cmd,
   output dbl_pkg::dbl_bank_t [BANKS-1:0] bank_state,
   output logic all_idle
);
   import dbl_pkg::*;
   localparam int CW = 8;
   localparam logic [CW-1:0] T_CLOSE = CW'(`DBL_CYC(`DBL_CLOSE_TO_IDLE_NS));
   localparam logic [CW-1:0] T_OPEN = CW'(`DBL_CYC(`DBL_OPEN_TO_ACCESS_NS));
   localparam logic [CW-1:0] T_WR = CW'(`DBL_CYC(`DBL_POST_STORE_NS));
   localparam logic [CW-1:0] T_REF = CW'(`DBL_CYC(`DBL_REFRESH_CYCLE_NS));
   localparam logic [CW-1:0] T_MODE = CW'(`DBL_MODE_LOAD_CYCLES);
   localparam logic [CW-1:0] T_BURST = CW'(`DBL_BURST_CYCLES);

   initial begin
      if (BANKS != (1 << BA_W) || ADDR_W <= `DBL_AUTO_CLOSE_BIT)
         $error("dbl_bank_legality: bad bank or address width");
   end

   function automatic dbl_cmd_t decode(input logic cs_n, input logic ras_n,
                                       input logic cas_n, input logic we_n);
      if (cs_n)
         return DBL_CMD_UNSEL;
      unique case ({ras_n, cas_n, we_n})
         3'h7: return DBL_CMD_NOP;
         3'h5: return DBL_CMD_READ;
         3'h4: return DBL_CMD_STORE;
         3'h3: return DBL_CMD_OPEN;
         3'h2: return DBL_CMD_CLOSE;
         3'h1: return DBL_CMD_RENEW;
         default: return DBL_CMD_MODE;
      endcase
   endfunction

   dbl_cmd_t cmd;
   logic auto_close_flag;
   logic quiet;
   dbl_dev_t dev;
   logic [CW-1:0] dev_cnt;
   logic [CW-1:0] cnt [BANKS];
   logic [BANKS-1:0] bank_bad;
   logic next_illegal;
   logic [BANKS-1:0] take;
   logic [BANKS-1:0] close_me;
   logic [BANKS-1:0] expired;

   assign cmd = decode(chip_sel_n, row_strobe_n, column_strobe_n,
                       write_strobe_n);
   assign auto_close_flag = addr[`DBL_AUTO_CLOSE_BIT];
   assign quiet = (cmd == DBL_CMD_NOP) || (cmd == DBL_CMD_UNSEL);

   always_comb begin
      all_idle = 1'b1;
      for (int b = 0; b < BANKS; b++)
         if (bank_state[b] != DBL_IDLE)
            all_idle = 1'b0;
   end

   // Per-bank legality of bank commands
   always_comb begin
      for (int b = 0; b < BANKS; b++) begin
         logic hit;
         hit = (BA_W'(b) == bank_addr);
         bank_bad[b] = 1'b0;
         if (!quiet && dev == DBL_DEV_NORMAL) begin
            unique case (bank_state[b])
               DBL_IDLE:
                  bank_bad[b] = hit && (cmd == DBL_CMD_READ ||
                                        cmd == DBL_CMD_STORE);
               DBL_ACTIVE:
                  bank_bad[b] = hit && cmd == DBL_CMD_OPEN;
               DBL_RD_AC, DBL_WR_AC, DBL_OPENING, DBL_WREC_AC:
                  bank_bad[b] = (hit || (cmd == DBL_CMD_CLOSE &&
                                auto_close_flag)) &&
                                cmd != DBL_CMD_RENEW &&
                                cmd != DBL_CMD_MODE;
               DBL_CLOSING:
                  bank_bad[b] = hit && (cmd == DBL_CMD_READ ||
                                cmd == DBL_CMD_STORE ||
                                cmd == DBL_CMD_OPEN);
               DBL_WREC:
                  bank_bad[b] = ((hit && cmd != DBL_CMD_STORE) ||
                                (cmd == DBL_CMD_CLOSE && auto_close_flag)) &&
                                cmd != DBL_CMD_RENEW &&
                                cmd != DBL_CMD_MODE;
            endcase
         end
      end
   end

   // Global commands need all idle; refresh and mode load need quiet
   always_comb begin
      next_illegal = |bank_bad;
      if (!quiet && dev != DBL_DEV_NORMAL)
         next_illegal = 1'b1;
      if ((cmd == DBL_CMD_RENEW || cmd == DBL_CMD_MODE) && !all_idle)
         next_illegal = 1'b1;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         illegal_cmd <= 1'b0;
         last_cmd <= DBL_CMD_UNSEL;
      end else begin
         illegal_cmd <= next_illegal;
         last_cmd <= cmd;
      end
   end

   // Device-wide refresh and mode load timing
   always_ff @(posedge clock) begin
      if (rst) begin
         dev <= DBL_DEV_NORMAL;
         dev_cnt <= '0;
      end else if (dev != DBL_DEV_NORMAL) begin
         if (dev_cnt <= CW'(1))
            dev <= DBL_DEV_NORMAL;
         else
            dev_cnt <= dev_cnt - CW'(1);
      end else if (!next_illegal && cmd == DBL_CMD_RENEW) begin
         dev <= DBL_DEV_REFRESH;
         dev_cnt <= T_REF;
      end else if (!next_illegal && cmd == DBL_CMD_MODE) begin
         dev <= DBL_DEV_MODE;
         dev_cnt <= T_MODE;
      end
   end

   // Refused commands change no bank, a refused close-all included
   always_comb begin
      for (int b = 0; b < BANKS; b++) begin
         take[b] = (BA_W'(b) == bank_addr) && !next_illegal;
         close_me[b] = cmd == DBL_CMD_CLOSE && !next_illegal &&
                       ((BA_W'(b) == bank_addr) || auto_close_flag);
         expired[b] = cnt[b] <= CW'(1);
      end
   end

   // Bank state machines; illegal commands leave the state unchanged
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int b = 0; b < BANKS; b++) begin
            bank_state[b] <= DBL_IDLE;
            cnt[b] <= '0;
         end
      end else begin
         for (int b = 0; b < BANKS; b++) begin
            if (!expired[b])
               cnt[b] <= cnt[b] - CW'(1);
            unique case (bank_state[b])
               DBL_IDLE:
                  if (take[b] && cmd == DBL_CMD_OPEN) begin
                     bank_state[b] <= DBL_OPENING;
                     cnt[b] <= T_OPEN;
                  end else if (close_me[b]) begin
                     bank_state[b] <= DBL_CLOSING;
                     cnt[b] <= T_CLOSE;
                  end
               DBL_ACTIVE:
                  if (close_me[b]) begin
                     bank_state[b] <= DBL_CLOSING;
                     cnt[b] <= T_CLOSE;
                  end else if (take[b] && cmd == DBL_CMD_READ &&
                               auto_close_flag) begin
                     bank_state[b] <= DBL_RD_AC;
                     cnt[b] <= T_BURST;
                  end else if (take[b] && cmd == DBL_CMD_STORE) begin
                     bank_state[b] <= auto_close_flag ? DBL_WR_AC : DBL_WREC;
                     cnt[b] <= auto_close_flag ? T_BURST : T_WR;
                  end
               DBL_RD_AC:
                  if (expired[b]) begin
                     bank_state[b] <= DBL_CLOSING;
                     cnt[b] <= T_CLOSE;
                  end
               DBL_WR_AC:
                  if (expired[b]) begin
                     bank_state[b] <= DBL_WREC_AC;
                     cnt[b] <= T_WR;
                  end
               DBL_CLOSING:
                  if (expired[b])
                     bank_state[b] <= DBL_IDLE;
               DBL_OPENING:
                  if (expired[b])
                     bank_state[b] <= DBL_ACTIVE;
               DBL_WREC:
                  if (take[b] && cmd == DBL_CMD_STORE) begin
                     bank_state[b] <= auto_close_flag ? DBL_WR_AC : DBL_WREC;
                     cnt[b] <= auto_close_flag ? T_BURST : T_WR;
                  end else if (expired[b])
                     bank_state[b] <= DBL_ACTIVE;
               DBL_WREC_AC:
                  if (expired[b]) begin
                     bank_state[b] <= DBL_CLOSING;
                     cnt[b] <= T_CLOSE;
                  end
               default:
                  bank_state[b] <= DBL_IDLE;
            endcase
         end
      end
   end

   a_open_bad: assert property (@(posedge clock) disable iff (rst)
      (bank_state[0] == DBL_OPENING && cmd == DBL_CMD_READ &&
       bank_addr == '0) |=> illegal_cmd)
      else $error("read to opening bank not flagged");
   a_mode_quiet: assert property (@(posedge clock) disable iff (rst)
      (dev == DBL_DEV_MODE && !quiet) |=> illegal_cmd)
      else $error("command during mode load not flagged");
   a_refresh_ends: assert property (@(posedge clock) disable iff (rst)
      (dev == DBL_DEV_NORMAL && cmd == DBL_CMD_RENEW && !next_illegal)
      |=> dev == DBL_DEV_REFRESH ##[1:8] dev == DBL_DEV_NORMAL)
      else $error("refresh did not end in time");
   a_close_idles: assert property (@(posedge clock) disable iff (rst)
      (bank_state[0] == DBL_CLOSING && cnt[0] <= CW'(1))
      |=> bank_state[0] == DBL_IDLE)
      else $error("closing bank did not go idle");
   a_renew_idle: assert property (@(posedge clock) disable iff (rst)
      (cmd == DBL_CMD_RENEW && !all_idle) |=> illegal_cmd)
      else $error("refresh with busy bank not flagged");
   a_unsel_quiet: assert property (@(posedge clock) disable iff (rst)
      chip_sel_n |=> !illegal_cmd)
      else $error("unselected cycle flagged");
   a_open_active: assert property (@(posedge clock) disable iff (rst)
      (bank_state[0] == DBL_OPENING && cnt[0] <= CW'(1))
      |=> bank_state[0] == DBL_ACTIVE)
      else $error("opening bank did not activate");
   a_close_all: assert property (@(posedge clock) disable iff (rst)
      (bank_state[0] == DBL_ACTIVE && cmd == DBL_CMD_CLOSE &&
       auto_close_flag && dev == DBL_DEV_NORMAL && !next_illegal)
      |=> bank_state[0] == DBL_CLOSING)
      else $error("close all missed a bank");
endmodule
`default_nettype wire

// [dbl_consts.svh]
// Constants for the bank command legality block
`ifndef DBL_CONSTS_SVH
`define DBL_CONSTS_SVH
`define DBL_CLK_PERIOD_NS 100
`define DBL_CLOSE_TO_IDLE_NS 15
`define DBL_OPEN_TO_ACCESS_NS 15
`define DBL_POST_STORE_NS 15
`define DBL_REFRESH_CYCLE_NS 60
`define DBL_MODE_LOAD_CYCLES 2
`define DBL_BURST_CYCLES 4
`define DBL_CYC(ns) (((ns) + `DBL_CLK_PERIOD_NS - 1) / `DBL_CLK_PERIOD_NS)
`define DBL_AUTO_CLOSE_BIT 10
`endif

// [dbl_ctrl_model.sv]
// Controller model that encodes commands onto the strobes
`timescale 1ns/10ps
`default_nettype none
module dbl_ctrl_model (
   input wire dbl_pkg::dbl_cmd_t cmd,
   input wire logic [2:0] bank,
   input wire logic auto_close,
   output logic chip_sel_n,
   output logic row_strobe_n,
   output logic column_strobe_n,
   output logic write_strobe_n,
   output logic [2:0] bank_addr,
   output logic [13:0] addr
);
   import dbl_pkg::*;
   logic [2:0] s;
   assign {row_strobe_n, column_strobe_n, write_strobe_n} = s;
   always_comb begin
      chip_sel_n = 1'b0;
      bank_addr = bank;
      addr = 14'h0155;
      addr[10] = auto_close;
      case (cmd)
         DBL_CMD_NOP: s = 3'h7;
         DBL_CMD_READ: s = 3'h5;
         DBL_CMD_STORE: s = 3'h4;
         DBL_CMD_OPEN: s = 3'h3;
         DBL_CMD_CLOSE: s = 3'h2;
         DBL_CMD_RENEW: s = 3'h1;
         DBL_CMD_MODE: s = 3'h0;
         default: begin
            // Deselect: live junk on the strobes, the device must ignore it
            chip_sel_n = 1'b1;
            s = 3'h0;
            bank_addr = ~bank;
            addr = 14'h2aaa;
         end
      endcase
   end
endmodule
`default_nettype wire

// [dbl_pkg.sv]
// Types for the bank command legality block
package dbl_pkg;
   typedef enum logic [3:0] {
      DBL_CMD_UNSEL, DBL_CMD_NOP, DBL_CMD_READ, DBL_CMD_STORE,
      DBL_CMD_OPEN, DBL_CMD_CLOSE, DBL_CMD_RENEW, DBL_CMD_MODE
   } dbl_cmd_t;
   typedef enum logic [3:0] {
      DBL_IDLE, DBL_ACTIVE, DBL_RD_AC, DBL_WR_AC, DBL_CLOSING,
      DBL_OPENING, DBL_WREC, DBL_WREC_AC
   } dbl_bank_t;
   typedef enum logic [1:0] {
      DBL_DEV_NORMAL, DBL_DEV_REFRESH, DBL_DEV_MODE
   } dbl_dev_t;
endpackage

// [tb_dbl_bank_legality.sv]
// Self-checking bench for the bank command legality block
`timescale 1ns/10ps
`default_nettype none
module tb_dbl_bank_legality;
   import dbl_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   dbl_cmd_t cmd = DBL_CMD_NOP;
   logic [2:0] bank = 3'h0;
   logic ac = 1'b0;
   logic cs_n, ras_n, cas_n, we_n, illegal_cmd, all_idle;
   logic [2:0] ba;
   logic [13:0] addr;
   dbl_cmd_t last_cmd;
   dbl_bank_t [7:0] bank_state;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;
   int i;
   dbl_ctrl_model ctrl (.cmd(cmd), .bank(bank), .auto_close(ac),
      .chip_sel_n(cs_n), .row_strobe_n(ras_n), .column_strobe_n(cas_n),
      .write_strobe_n(we_n), .bank_addr(ba), .addr(addr));
   dbl_bank_legality DUT (.clock(clock), .rst(rst), .chip_sel_n(cs_n),
      .row_strobe_n(ras_n), .column_strobe_n(cas_n), .write_strobe_n(we_n),
      .bank_addr(ba), .addr(addr), .illegal_cmd(illegal_cmd),
      .last_cmd(last_cmd), .bank_state(bank_state), .all_idle(all_idle));
   always #50 clock = ~clock;
   task automatic fail(input string m);
      err_total++;
      $display("mismatch at %0t: %s", $time, m);
   endtask
   task automatic close_out;
      $display("errors %0d of %0d compares", err_total, compares);
      if (err_total == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Timeout well above the few dozen cycles the run needs
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         fail("timeout");
         close_out();
      end
   end
   // One command per cycle, outputs judged just after the sampling edge
   task automatic step(input dbl_cmd_t c, input int b, input logic a,
         input int eb, input dbl_bank_t es, input logic ei);
      @(negedge clock);
      cmd = c;
      bank = b[2:0];
      ac = a;
      @(posedge clock);
      #1;
      compares += 2;
      if (bank_state[eb] !== es) fail("bank state");
      if (illegal_cmd !== ei) fail("illegal flag");
   endtask
   task automatic t_open_read;
      step(DBL_CMD_OPEN, 0, 0, 0, DBL_OPENING, 0);
      step(DBL_CMD_READ, 0, 0, 0, DBL_ACTIVE, 1);
      step(DBL_CMD_READ, 0, 1, 0, DBL_RD_AC, 0);
      step(DBL_CMD_OPEN, 0, 0, 0, DBL_RD_AC, 1);
      step(DBL_CMD_OPEN, 1, 0, 1, DBL_OPENING, 0);
      step(DBL_CMD_NOP, 0, 0, 0, DBL_RD_AC, 0);
      step(DBL_CMD_UNSEL, 0, 0, 0, DBL_CLOSING, 0);
      step(DBL_CMD_CLOSE, 0, 0, 0, DBL_IDLE, 0);
   endtask
   task automatic t_write;
      step(DBL_CMD_STORE, 1, 0, 1, DBL_WREC, 0);
      step(DBL_CMD_STORE, 1, 0, 1, DBL_WREC, 0);
      step(DBL_CMD_READ, 1, 0, 1, DBL_ACTIVE, 1);
      step(DBL_CMD_STORE, 1, 1, 1, DBL_WR_AC, 0);
      for (i = 0; i < 2; i++) begin
         step(DBL_CMD_NOP, 1, 0, 1, DBL_WR_AC, 0);
      end
      // Close-all refused while bank 1 bursts: idle bank 0 stays put
      step(DBL_CMD_CLOSE, 0, 1, 1, DBL_WR_AC, 1);
      compares++;
      if (bank_state[0] !== DBL_IDLE) fail("refused close-all");
      step(DBL_CMD_NOP, 1, 0, 1, DBL_WREC_AC, 0);
      step(DBL_CMD_STORE, 1, 0, 1, DBL_CLOSING, 1);
      step(DBL_CMD_NOP, 1, 0, 1, DBL_IDLE, 0);
   endtask
   task automatic t_global;
      step(DBL_CMD_RENEW, 0, 0, 2, DBL_IDLE, 0);
      step(DBL_CMD_OPEN, 2, 0, 2, DBL_IDLE, 1);
      step(DBL_CMD_MODE, 0, 0, 2, DBL_IDLE, 0);
      step(DBL_CMD_OPEN, 2, 0, 2, DBL_IDLE, 1);
      step(DBL_CMD_NOP, 0, 0, 2, DBL_IDLE, 0);
      step(DBL_CMD_OPEN, 2, 0, 2, DBL_OPENING, 0);
      step(DBL_CMD_UNSEL, 0, 0, 2, DBL_ACTIVE, 0);
      compares++;
      if (last_cmd !== DBL_CMD_UNSEL) fail("unselected decode");
      step(DBL_CMD_OPEN, 0, 0, 0, DBL_OPENING, 0);
      step(DBL_CMD_NOP, 0, 0, 0, DBL_ACTIVE, 0);
      step(DBL_CMD_RENEW, 0, 0, 0, DBL_ACTIVE, 1);
      step(DBL_CMD_MODE, 0, 0, 2, DBL_ACTIVE, 1);
      step(DBL_CMD_CLOSE, 5, 1, 2, DBL_CLOSING, 0);
      compares++;
      if (bank_state[0] !== DBL_CLOSING) fail("close all");
      step(DBL_CMD_NOP, 0, 0, 0, DBL_IDLE, 0);
      compares++;
      if (all_idle !== 1'b1) fail("all idle");
   endtask
   initial begin
      repeat (2) @(posedge clock);
      #1;
      compares++;
      if (last_cmd !== DBL_CMD_UNSEL || all_idle !== 1'b1) fail("reset");
      @(negedge clock);
      rst = 1'b0;
      t_open_read();
      t_write();
      t_global();
      close_out();
   end
endmodule
`default_nettype wire
